/* File: hsc_consts.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the homing sequencer
// Assumes: 32-bit APB data, byte addresses on paddr[7:0]
// Notes:   Definitions only
`ifndef HSC_CONSTS_SVH
`define HSC_CONSTS_SVH

`define HSC_CLK_PERIOD_NS   100
`define HSC_MS_NS           1000000
`define HSC_CYC_PER_MS      (`HSC_MS_NS / `HSC_CLK_PERIOD_NS)

`define HSC_OFF_CTRL        8'h00
`define HSC_OFF_SELECT      8'h04
`define HSC_OFF_SHIFT       8'h08
`define HSC_OFF_COORD       8'h0C
`define HSC_OFF_RANGE       8'h10
`define HSC_OFF_OTDECEL     8'h14
`define HSC_OFF_STOPTIME    8'h18
`define HSC_OFF_STOPTORQ    8'h1C
`define HSC_OFF_THIRDTORQ   8'h20
`define HSC_OFF_STATUS      8'h24
`define HSC_OFF_REFPOS      8'h28

`define HSC_CTRL_START      0
`define HSC_CTRL_STARTDIR   1
`define HSC_SEL_REF_LSB     0
`define HSC_SEL_DECEL_LSB   4
`define HSC_SEL_EDGE        8
`define HSC_SEL_CREEPRET    9
`define HSC_SEL_OTACT       10
`define HSC_SEL_POSTDIR     11

`define HSC_REF_LS          3'h0
`define HSC_REF_Z           3'h1
`define HSC_REF_POT         3'h2
`define HSC_REF_NOT         3'h3
`define HSC_REF_INT         3'h4
`define HSC_REF_STOP        3'h5
`define HSC_DEC_LS          2'h0
`define HSC_DEC_POT         2'h1
`define HSC_DEC_NOT         2'h2
`define HSC_DEC_Z           2'h3

`define HSC_RST_REF         3'h1
`define HSC_RST_DECEL       2'h0
`define HSC_RST_SHIFT       32'h0000_03E8
`define HSC_RST_COORD       32'h0000_0000
`define HSC_RST_RANGE       32'h0000_0000
`define HSC_RST_OTDECEL     20'h0_03E8
`define HSC_RST_STOPTIME    14'h0000
`define HSC_RST_STOPTORQ    7'h00
`define HSC_RST_THIRDTORQ   9'h12C

`endif

/* File: hsc_pkg.sv */
// Purpose: Types of the homing sequencer
// Assumes: Nothing beyond the constants header
// Notes:   The edge finder, stop timer and top each keep their state in one of these structs
package hsc_pkg;

	typedef enum logic [2:0] {
		HSC_IDLE,
		HSC_FAST,
		HSC_RETURN,
		HSC_CREEP,
		HSC_SHIFT
	} hsc_phase_t;

	typedef struct packed {
		logic prev;
		logic rise;
		logic fall;
	} hsc_edge_t;

	typedef struct packed {
		logic [13:0] pre;
		logic [13:0] ms;
		logic        done;
	} hsc_timer_t;

	typedef struct packed {
		hsc_phase_t  phase;
		logic [2:0]  shiftRef;
		logic [1:0]  decelSel;
		logic        edgeSel;
		logic        creepRet;
		logic        otAction;
		logic        postDir;
		logic        startDir;
		logic [31:0] shiftDist;
		logic [31:0] coord;
		logic [31:0] range;
		logic [19:0] otDecel;
		logic [13:0] stopTime;
		logic [6:0]  stopTorq;
		logic [8:0]  thirdTorq;
		logic [31:0] refPos;
		logic [32:0] target;
		logic        fwd;
		logic        creep;
		logic        otSeen;
		logic        otDecelOn;
		logic        otBrake;
		logic        homed;
		logic        cancelled;
		logic        complete;
		logic        loadPulse;
		logic        rdy;
		logic [31:0] prdata;
		logic        slverr;
	} hsc_state_t;

endpackage

/* File: hsc_edge.sv */
// Purpose: Edge finder for a switch or pulse input
// Assumes: Input synchronous to clk
// Notes:   Outputs are registered, one cycle after the level change
`timescale 1ns/1ns
`include "hsc_consts.svh"
module hsc_edge
	import hsc_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic din,
	output logic      rise,
	output logic      fall
);
	hsc_edge_t st_reg;
	hsc_edge_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.prev = din;
		st_next.rise = din & ~st_reg.prev;
		st_next.fall = ~din & st_reg.prev;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign rise = st_reg.rise;
	assign fall = st_reg.fall;
endmodule

/* File: hsc_stop_timer.sv */
// Purpose: Stopper contact timer in whole milliseconds
// Assumes: run high while the torque sits at the stopper limit
// Notes:   Any drop of run restarts the count
`timescale 1ns/1ns
`include "hsc_consts.svh"
module hsc_stop_timer
	import hsc_pkg::*;
#(
	parameter int CYC_PER_MS = `HSC_CYC_PER_MS
)
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        run,
	input  wire logic [13:0] limitMs,
	output logic             done
);
	hsc_timer_t st_reg;
	hsc_timer_t st_next;

	always_comb begin
		st_next = st_reg;
		if (!run) begin
			st_next = '0;
		end else if (st_reg.ms >= limitMs) begin
			st_next.done = 1'b1;
		end else if (st_reg.pre == 14'(CYC_PER_MS - 1)) begin
			st_next.pre = '0;
			st_next.ms = st_reg.ms + 14'h0001;
		end else begin
			st_next.pre = st_reg.pre + 14'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign done = st_reg.done;
endmodule

/* File: hsc_top.sv */
// Purpose: Homing sequencer: reference choice, creep trigger, shift travel, coordinate load
// Assumes: Motion stage follows moveEnable/moveForward/creepSpeed; position is signed units
// Notes:   APB slave, pready one cycle after the access phase starts
// Behaviour
// - Reference code: 0 switch, 1 Z-phase, 2 +overtravel, 3 -overtravel, 4 interrupt, 5 stopper.
// - Home lies shift distance from the reference, in post-reference direction.
// - Interrupt and home switch references latch position at their edge; overtravels act on level.
// - Z-phase pulses count only once the encoder reports Z valid after rotation.
// - With Z reference, trigger code selects creep switch: switch, +OT, -OT, Z.
// - Shift starts at the first Z pulse after the creep trigger.
// - Trigger Z means creep from start and shift from first Z pulse.
// - Home switch counts on rising edge for setting 0, trailing edge for 1.
// - Shift distance 0 to 2000000000 units, default 1000.
// - Creep return backs off before reference, then creeps onto it again.
// - Normal finish loads the home coordinate into current position, default 0.
// - Complete flag while position within window of home; window 0 holds it on.
// - Overtravel during homing decelerates with programmed time, default 100.0 ms.
// - Overtravel action 1 stops homing and brakes under third torque limit.
// - Stopper time and torque limit apply only with reference code 5.
// - Stopper contact time 0 to 10000 ms, torque limit 0 to 100 percent.
// - Forward means position increasing, reverse means position decreasing.
// - Overtravel as creep trigger makes motion head away from that switch.
// - Overtravel action 0 reverses motion on first overtravel during homing.
`timescale 1ns/1ns
`include "hsc_consts.svh"
module hsc_top
	import hsc_pkg::*;
#(
	parameter int CYC_PER_MS = `HSC_CYC_PER_MS
)
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        homeLimitSwitch,
	input  wire logic        positiveOvertravel,
	input  wire logic        negativeOvertravel,
	input  wire logic        interruptInput,
	input  wire logic        encoderZ,
	input  wire logic        zPhaseValid,
	input  wire logic        torqueAtLimit,
	input  wire logic [31:0] currentPosition,
	output logic             moveEnable,
	output logic             moveForward,
	output logic             creepSpeed,
	output logic             otDecelActive,
	output logic [19:0]      otDecelTime,
	output logic             thirdTorqueBrake,
	output logic [8:0]       thirdTorqueLimit,
	output logic             stopperLimitOn,
	output logic [6:0]       stopperTorqueLimit,
	output logic             positionLoad,
	output logic [31:0]      positionLoadValue,
	output logic             homingBusy,
	output logic             homingComplete
);
	hsc_state_t st_reg;
	hsc_state_t st_next;

	logic lsRise;
	logic lsFall;
	logic intRise;
	logic zRise;
	logic stopDone;
	logic lsEvent;
	logic zEvent;
	logic refEvent;
	logic refLevel;
	logic decelEvent;
	logic dirAfter;
	logic otAhead;
	logic moving;
	logic reached;
	logic inWindow;
	logic [32:0] posExt;
	logic [32:0] distExt;
	logic [32:0] diff;
	logic [32:0] absDiff;

	////////////////////////////////////////////////////////////////////////////////
	// Input events

	hsc_edge u_ls_edge (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.din (homeLimitSwitch),
		.rise(lsRise),
		.fall(lsFall)
	);

	hsc_edge u_int_edge (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.din (interruptInput),
		.rise(intRise),
		.fall()
	);

	hsc_edge u_z_edge (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.din (encoderZ),
		.rise(zRise),
		.fall()
	);

	assign moving = (st_reg.phase != HSC_IDLE);

	// Timer only armed in stopper mode, so its settings are inert otherwise
	hsc_stop_timer #(
		.CYC_PER_MS(CYC_PER_MS)
	) u_stop_timer (
		.clk    (clk),
		.rst    (rst),
		.ce     (ce),
		.run    (moving && st_reg.shiftRef == `HSC_REF_STOP && torqueAtLimit),
		.limitMs(st_reg.stopTime),
		.done   (stopDone)
	);

	assign lsEvent = st_reg.edgeSel ? lsFall : lsRise;
	assign zEvent = zRise & zPhaseValid;

	always_comb begin
		refEvent = 1'b0;
		refLevel = 1'b0;
		case (st_reg.shiftRef)
			`HSC_REF_LS: begin
				refEvent = lsEvent;
				refLevel = homeLimitSwitch;
			end
			`HSC_REF_Z: begin
				refEvent = zEvent;
			end
			`HSC_REF_POT: begin
				refEvent = positiveOvertravel;
				refLevel = positiveOvertravel;
			end
			`HSC_REF_NOT: begin
				refEvent = negativeOvertravel;
				refLevel = negativeOvertravel;
			end
			`HSC_REF_INT: begin
				refEvent = intRise;
				refLevel = interruptInput;
			end
			`HSC_REF_STOP: begin
				refEvent = stopDone;
			end
			default: begin
				refEvent = 1'b0;
			end
		endcase
	end

	always_comb begin
		case (st_reg.decelSel)
			`HSC_DEC_LS: begin
				decelEvent = lsEvent;
				dirAfter = ~st_reg.postDir;
			end
			`HSC_DEC_POT: begin
				decelEvent = positiveOvertravel;
				dirAfter = 1'b0;
			end
			`HSC_DEC_NOT: begin
				decelEvent = negativeOvertravel;
				dirAfter = 1'b1;
			end
			default: begin
				decelEvent = zEvent;
				dirAfter = ~st_reg.startDir;
			end
		endcase
		if (st_reg.shiftRef != `HSC_REF_Z) begin
			decelEvent = 1'b0;
			dirAfter = ~st_reg.postDir;
		end
	end

	// Overtravel in the travel direction, ignored while either overtravel is the reference or, in fast travel, the trigger
	always_comb begin
		otAhead = st_reg.fwd ? positiveOvertravel : negativeOvertravel;
		if (st_reg.shiftRef == `HSC_REF_POT || st_reg.shiftRef == `HSC_REF_NOT) begin
			otAhead = 1'b0;
		end
		if (st_reg.shiftRef == `HSC_REF_Z
			&& (st_reg.decelSel == `HSC_DEC_POT || st_reg.decelSel == `HSC_DEC_NOT)
			&& st_reg.phase == HSC_FAST) begin
			otAhead = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shift target and home window

	// 33 bits so the signed sum never wraps at the range ends
	assign posExt = {currentPosition[31], currentPosition};
	assign distExt = {1'b0, st_reg.shiftDist};
	assign reached = st_reg.fwd ? ($signed(posExt) >= $signed(st_reg.target))
		: ($signed(posExt) <= $signed(st_reg.target));
	assign diff = posExt - {st_reg.coord[31], st_reg.coord};
	assign absDiff = diff[32] ? (33'h0_0000_0000 - diff) : diff;
	assign inWindow = (st_reg.range == 32'h0000_0000) || (absDiff <= {1'b0, st_reg.range});

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer and registers

	always_comb begin
		st_next = st_reg;
		st_next.loadPulse = 1'b0;
		st_next.rdy = 1'b0;
		st_next.slverr = 1'b0;

		// APB read, answered one cycle into the access phase
		if (psel && penable && !st_reg.rdy) begin
			st_next.rdy = 1'b1;
			case (paddr)
				`HSC_OFF_CTRL: st_next.prdata = {30'h0, st_reg.startDir, 1'b0};
				`HSC_OFF_SELECT: st_next.prdata = {20'h0, st_reg.postDir, st_reg.otAction,
					st_reg.creepRet, st_reg.edgeSel, 2'h0, st_reg.decelSel, 1'b0, st_reg.shiftRef};
				`HSC_OFF_SHIFT: st_next.prdata = st_reg.shiftDist;
				`HSC_OFF_COORD: st_next.prdata = st_reg.coord;
				`HSC_OFF_RANGE: st_next.prdata = st_reg.range;
				`HSC_OFF_OTDECEL: st_next.prdata = {12'h000, st_reg.otDecel};
				`HSC_OFF_STOPTIME: st_next.prdata = {18'h0_0000, st_reg.stopTime};
				`HSC_OFF_STOPTORQ: st_next.prdata = {25'h000_0000, st_reg.stopTorq};
				`HSC_OFF_THIRDTORQ: st_next.prdata = {23'h00_0000, st_reg.thirdTorq};
				`HSC_OFF_STATUS: st_next.prdata = {25'h000_0000, st_reg.phase, st_reg.homed,
					st_reg.cancelled, moving, st_reg.complete};
				`HSC_OFF_REFPOS: st_next.prdata = st_reg.refPos;
				default: begin
					st_next.prdata = 32'h0000_0000;
					st_next.slverr = !pwrite;
				end
			endcase
		end

		// Motion sequence
		case (st_reg.phase)
			HSC_IDLE: begin
				st_next.creep = 1'b0;
				st_next.otDecelOn = 1'b0;
			end
			HSC_FAST: begin
				if (st_reg.shiftRef == `HSC_REF_Z) begin
					if (decelEvent) begin
						st_next.phase = HSC_CREEP;
						st_next.creep = 1'b1;
						st_next.fwd = dirAfter;
						st_next.otDecelOn = 1'b0;
					end
				end else if (refEvent) begin
					st_next.refPos = currentPosition;
					st_next.otDecelOn = 1'b0;
					if (st_reg.creepRet && refLevel) begin
						st_next.phase = HSC_RETURN;
						st_next.creep = 1'b1;
						st_next.fwd = ~dirAfter;
					end else begin
						st_next.phase = HSC_SHIFT;
						st_next.creep = 1'b1;
						st_next.fwd = dirAfter;
					end
				end
			end
			HSC_RETURN: begin
				if (!refLevel) begin
					st_next.phase = HSC_CREEP;
					st_next.fwd = dirAfter;
				end
			end
			HSC_CREEP: begin
				if (refEvent) begin
					st_next.refPos = currentPosition;
					st_next.phase = HSC_SHIFT;
					st_next.fwd = dirAfter;
				end
			end
			HSC_SHIFT: begin
				if (reached) begin
					st_next.phase = HSC_IDLE;
					st_next.loadPulse = 1'b1;
					st_next.homed = 1'b1;
				end
			end
			default: begin
				st_next.phase = HSC_IDLE;
			end
		endcase

		// Target follows the latched reference and the direction taken from it
		if (st_next.phase == HSC_SHIFT) begin
			st_next.target = st_next.fwd
				? ({st_next.refPos[31], st_next.refPos} + distExt)
				: ({st_next.refPos[31], st_next.refPos} - distExt);
		end

		// Overtravel during search phases
		if ((st_reg.phase == HSC_FAST || st_reg.phase == HSC_CREEP) && otAhead) begin
			if (st_reg.otAction || st_reg.otSeen) begin
				st_next.phase = HSC_IDLE;
				st_next.otBrake = 1'b1;
				st_next.cancelled = 1'b1;
				st_next.homed = 1'b0;
			end else begin
				st_next.fwd = ~st_reg.fwd;
				st_next.otSeen = 1'b1;
				st_next.otDecelOn = 1'b1;
			end
		end

		// APB write on the completing edge
		if (psel && penable && pwrite && st_reg.rdy) begin
			case (paddr)
				`HSC_OFF_CTRL: begin
					st_next.startDir = pwdata[`HSC_CTRL_STARTDIR];
					if (pwdata[`HSC_CTRL_START] && !moving) begin
						st_next.homed = 1'b0;
						st_next.cancelled = 1'b0;
						st_next.otBrake = 1'b0;
						st_next.otSeen = 1'b0;
						st_next.otDecelOn = 1'b0;
						st_next.fwd = ~pwdata[`HSC_CTRL_STARTDIR];
						if (st_reg.shiftRef == `HSC_REF_Z && st_reg.decelSel == `HSC_DEC_Z) begin
							st_next.phase = HSC_CREEP;
							st_next.creep = 1'b1;
						end else begin
							st_next.phase = HSC_FAST;
							st_next.creep = 1'b0;
						end
					end
				end
				`HSC_OFF_SELECT: begin
					st_next.shiftRef = pwdata[`HSC_SEL_REF_LSB +: 3];
					st_next.decelSel = pwdata[`HSC_SEL_DECEL_LSB +: 2];
					st_next.edgeSel = pwdata[`HSC_SEL_EDGE];
					st_next.creepRet = pwdata[`HSC_SEL_CREEPRET];
					st_next.otAction = pwdata[`HSC_SEL_OTACT];
					st_next.postDir = pwdata[`HSC_SEL_POSTDIR];
				end
				`HSC_OFF_SHIFT: st_next.shiftDist = pwdata;
				`HSC_OFF_COORD: st_next.coord = pwdata;
				`HSC_OFF_RANGE: st_next.range = pwdata;
				`HSC_OFF_OTDECEL: st_next.otDecel = pwdata[19:0];
				`HSC_OFF_STOPTIME: st_next.stopTime = pwdata[13:0];
				`HSC_OFF_STOPTORQ: st_next.stopTorq = pwdata[6:0];
				`HSC_OFF_THIRDTORQ: st_next.thirdTorq = pwdata[8:0];
				default: begin
					st_next.slverr = 1'b0;
				end
			endcase
		end

		st_next.complete = st_next.homed && inWindow;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.phase <= HSC_IDLE;
			st_reg.shiftRef <= `HSC_RST_REF;
			st_reg.decelSel <= `HSC_RST_DECEL;
			st_reg.shiftDist <= `HSC_RST_SHIFT;
			st_reg.coord <= `HSC_RST_COORD;
			st_reg.range <= `HSC_RST_RANGE;
			st_reg.otDecel <= `HSC_RST_OTDECEL;
			st_reg.stopTime <= `HSC_RST_STOPTIME;
			st_reg.stopTorq <= `HSC_RST_STOPTORQ;
			st_reg.thirdTorq <= `HSC_RST_THIRDTORQ;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign pready = st_reg.rdy;
	assign prdata = st_reg.prdata;
	assign pslverr = st_reg.slverr;
	assign moveEnable = moving;
	assign moveForward = st_reg.fwd;
	assign creepSpeed = st_reg.creep;
	assign otDecelActive = st_reg.otDecelOn;
	assign otDecelTime = st_reg.otDecel;
	assign thirdTorqueBrake = st_reg.otBrake;
	assign thirdTorqueLimit = st_reg.thirdTorq;
	assign stopperLimitOn = moving && st_reg.shiftRef == `HSC_REF_STOP;
	assign stopperTorqueLimit = st_reg.stopTorq;
	assign positionLoad = st_reg.loadPulse;
	assign positionLoadValue = st_reg.coord;
	assign homingBusy = moving;
	assign homingComplete = st_reg.complete;
endmodule

/* File: hsc_top_assertions.sv */
// Purpose: Port checks of the homing sequencer
// Assumes: Settings are written only while idle
// Notes:   Shadows APB writes to know the selected modes
`timescale 1ns/1ns
`include "hsc_consts.svh"
module hsc_top_assertions #(
	parameter int CYC_PER_MS = `HSC_CYC_PER_MS
)
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        moveEnable,
	input wire logic        creepSpeed,
	input wire logic [19:0] otDecelTime,
	input wire logic        thirdTorqueBrake,
	input wire logic        stopperLimitOn,
	input wire logic        positionLoad,
	input wire logic [31:0] positionLoadValue,
	input wire logic        homingComplete
);
	logic [11:0] selReg;
	logic [31:0] coordReg;
	logic [19:0] decelReg;
	logic        wrHit;
	assign wrHit = psel && penable && pready && pwrite;
	always_ff @(posedge clk) begin
		if (rst) begin
			selReg   <= 12'h001;
			coordReg <= 32'h0000_0000;
			decelReg <= 20'h0_03E8;
		end else if (wrHit) begin
			case (paddr)
				`HSC_OFF_SELECT: selReg <= pwdata[11:0];
				`HSC_OFF_COORD: coordReg <= pwdata;
				`HSC_OFF_OTDECEL: decelReg <= pwdata[19:0];
				default: ;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_apb_wait: assert property (psel && penable && !pready |=> pready) else $error("pready late");
	chk_err_read: assert property (pslverr |-> pready && !pwrite) else $error("pslverr misplaced");
	chk_load_value: assert property (positionLoad |-> positionLoadValue == coordReg)
		else $error("load value wrong");
	chk_load_once: assert property (positionLoad |=> !positionLoad) else $error("load not a pulse");
	chk_load_stop: assert property (positionLoad |-> $fell(moveEnable)) else $error("load without stop");
	chk_stop_only: assert property (stopperLimitOn |-> selReg[2:0] == 3'h5 && moveEnable)
		else $error("stopper limit outside stopper homing");
	chk_z_creep: assert property (moveEnable && selReg[2:0] == 3'h1 && selReg[5:4] == 2'h3 |-> creepSpeed)
		else $error("homing speed with Z trigger");
	chk_start_clear: assert property ($rose(moveEnable) |-> ##[0:1] !homingComplete)
		else $error("complete kept at start");
	chk_brake_cancel: assert property ($rose(thirdTorqueBrake) |-> selReg[10] && !moveEnable)
		else $error("brake without cancel");
	chk_decel_time: assert property (otDecelTime == decelReg) else $error("decel time wrong");
	chk_done_set: assert property ($rose(homingComplete) |-> positionLoad || $past(positionLoad))
		else $error("complete without finish");
	cov_load: cover property (positionLoad);
	cov_brake: cover property ($rose(thirdTorqueBrake));
	cov_stopper: cover property (stopperLimitOn);
endmodule
bind hsc_top hsc_top_assertions #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.moveEnable(moveEnable), .creepSpeed(creepSpeed), .otDecelTime(otDecelTime), .thirdTorqueBrake(thirdTorqueBrake),
	.stopperLimitOn(stopperLimitOn), .positionLoad(positionLoad), .positionLoadValue(positionLoadValue),
	.homingComplete(homingComplete));

/* File: hsc_motor_model.sv */
// Purpose: Motor, encoder and machine switches for the homing sequencer
// Assumes: Homing speed 4 units a cycle, creep 1
// Notes:   Hard stopper at STOP_POS blocks forward travel
`timescale 1ns/1ns
module hsc_motor_model #(
	parameter int LS_POS   = 100,
	parameter int INT_POS  = 150,
	parameter int STOP_POS = 300,
	parameter int NOT_POS  = -50,
	parameter int POT_POS  = 400,
	parameter int ZV_DIST  = 40
)
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        moveEnable,
	input  wire logic        moveForward,
	input  wire logic        creepSpeed,
	input  wire logic        positionLoad,
	input  wire logic [31:0] positionLoadValue,
	output logic [31:0]      currentPosition,
	output logic             homeLimitSwitch,
	output logic             positiveOvertravel,
	output logic             negativeOvertravel,
	output logic             interruptInput,
	output logic             encoderZ,
	output logic             zPhaseValid,
	output logic             torqueAtLimit
);
	int pos, nxt, moved, step;
	assign step = creepSpeed ? 1 : 4;
	always_comb begin
		nxt = moveForward ? pos + step : pos - step;
		if (nxt > STOP_POS)
			nxt = STOP_POS;
		if (!moveEnable)
			nxt = pos;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			pos      <= 0;
			moved    <= 0;
			encoderZ <= 1'b0;
		end else begin
			// Crossing test, so fast travel cannot skip a mark
			encoderZ <= (nxt >>> 6) != (pos >>> 6);
			moved    <= moved + ((nxt > pos) ? nxt - pos : pos - nxt);
			pos      <= positionLoad ? $signed(positionLoadValue) : nxt;
		end
	end
	assign currentPosition    = pos;
	assign homeLimitSwitch    = pos >= LS_POS && pos < LS_POS + 20;
	assign interruptInput     = pos >= INT_POS && pos < INT_POS + 8;
	assign positiveOvertravel = pos >= POT_POS;
	assign negativeOvertravel = pos <= NOT_POS;
	assign zPhaseValid        = moved > ZV_DIST;
	assign torqueAtLimit      = moveEnable && moveForward && pos == STOP_POS;
endmodule

/* File: tb_top.sv */
// Purpose: Self-checking bench of the homing sequencer
// Assumes: Motor model defaults except ZV_DIST; positions below match them
// Notes:   CYC_PER_MS shortened to 10
`timescale 1ns/1ns
`include "hsc_consts.svh"
module tb_top;
	localparam logic [31:0] SHIFT = 32'h0000_0014;
	localparam logic [31:0] COORD = 32'h0000_0005;
	localparam logic [11:0] SEL [8] = '{12'h031, 12'h000, 12'h100, 12'h001, 12'h004, 12'h200, 12'h805, 12'h821};
	localparam logic [1:0]  CTL [8] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h3};
	localparam int          LO [8]  = '{128, 100, 120, 128, 150, 100, 300, 0};
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, e, loadSeen, otSeen;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q, stopPos, lastPos, currentPosition, positionLoadValue;
	logic        homeLimitSwitch, positiveOvertravel, negativeOvertravel, interruptInput, encoderZ;
	logic        zPhaseValid, torqueAtLimit, moveEnable, moveForward, creepSpeed, otDecelActive;
	logic        thirdTorqueBrake, stopperLimitOn, positionLoad, homingBusy, homingComplete;
	logic [19:0] otDecelTime;
	logic [8:0]  thirdTorqueLimit;
	logic [6:0]  stopperTorqueLimit;
	int          nErrors, cmpCount, cyc;
	hsc_top #(.CYC_PER_MS(10)) i_dut (.clk, .rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .homeLimitSwitch, .positiveOvertravel, .negativeOvertravel, .interruptInput,
		.encoderZ, .zPhaseValid, .torqueAtLimit, .currentPosition, .moveEnable, .moveForward, .creepSpeed,
		.otDecelActive, .otDecelTime, .thirdTorqueBrake, .thirdTorqueLimit, .stopperLimitOn, .stopperTorqueLimit,
		.positionLoad, .positionLoadValue, .homingBusy, .homingComplete);
	// Z trust distance beyond the first mark, so the first Z pulse must be ignored
	hsc_motor_model #(.ZV_DIST(70)) i_motor (.clk, .rst, .moveEnable, .moveForward, .creepSpeed, .positionLoad,
		.positionLoadValue, .currentPosition, .homeLimitSwitch, .positiveOvertravel, .negativeOvertravel,
		.interruptInput, .encoderZ, .zPhaseValid, .torqueAtLimit);
	////////////////////////////////////////////////////////////////
	task automatic giveVerdict;
		$display("Errors %0d, compares %0d", nErrors, cmpCount);
		if (nErrors == 0 && cmpCount > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			nErrors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic runHoming(input logic [11:0] s, input logic [1:0] c);
		apb(1'b1, `HSC_OFF_SELECT, {20'h0_0000, s});
		loadSeen = 1'b0;
		apb(1'b1, `HSC_OFF_CTRL, {30'h0000_0000, c});
		while (homingBusy !== 1'b1)
			@(posedge clk);
		@(posedge clk);
		chk(32'(homingComplete), 32'h0000_0000);
		while (homingBusy !== 1'b0)
			@(posedge clk);
		repeat (2) @(posedge clk);
	endtask
	task automatic hom(input logic [11:0] s, input logic [1:0] c, input int lo, input logic rv);
		runHoming(s, c);
		apb(1'b0, `HSC_OFF_REFPOS, 32'h0000_0000);
		chk(32'($signed(q) >= lo && $signed(q) < lo + 16), 32'h0000_0001);
		chk(stopPos, rv ? q - SHIFT : q + SHIFT);
		chk(currentPosition, COORD);
		chk(32'(homingComplete), 32'h0000_0001);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		lastPos <= currentPosition;
		// Position at the stop command; the stage coasts one more step
		if (positionLoad === 1'b1) begin
			stopPos  <= lastPos;
			loadSeen <= 1'b1;
		end
		if (otDecelActive === 1'b1)
			otSeen <= 1'b1;
		if (cyc == 20000) begin
			nErrors++;
			$display("ERROR %0t: timeout", $time);
			giveVerdict();
		end
	end
	initial begin
		rst     = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0000_0000;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, `HSC_OFF_SELECT, 32'h0000_0000);
		chk(q, 32'h0000_0001);
		apb(1'b0, `HSC_OFF_SHIFT, 32'h0000_0000);
		chk(q, 32'h0000_03E8);
		chk(32'(otDecelTime), 32'h0000_03E8);
		chk(32'(thirdTorqueLimit), 32'h0000_012C);
		apb(1'b1, `HSC_OFF_SHIFT, SHIFT);
		apb(1'b1, `HSC_OFF_COORD, COORD);
		apb(1'b1, `HSC_OFF_STOPTIME, 32'h0000_0002);
		apb(1'b1, `HSC_OFF_STOPTORQ, 32'h0000_0028);
		apb(1'b1, `HSC_OFF_OTDECEL, 32'h0000_04EC);
		@(negedge clk);
		chk(32'(stopperTorqueLimit), 32'h0000_0028);
		chk(32'(otDecelTime), 32'h0000_04EC);
		// Z trigger row runs first, while Z is not yet trusted
		for (int i = 0; i < 8; i++)
			hom(SEL[i], CTL[i], LO[i], i == 6);
		otSeen = 1'b0;
		hom(12'h000, 2'h3, 100, 1'b0);
		chk(32'(otSeen), 32'h0000_0001);
		runHoming(12'h400, 2'h3);
		chk(32'(thirdTorqueBrake), 32'h0000_0001);
		chk(32'(loadSeen), 32'h0000_0000);
		apb(1'b0, `HSC_OFF_STATUS, 32'h0000_0000);
		chk(q & 32'h0000_0005, 32'h0000_0004);
		apb(1'b0, 8'h30, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		chk(32'(e), 32'h0000_0001);
		giveVerdict();
	end
endmodule
